// [bce_pkg.sv]
// constants, opcodes and carrier types of the call/clear/decrement executor
package bce_pkg;

   // ------------------------------------------------------------
   // register byte offsets
   // ------------------------------------------------------------
   localparam logic [7:0] ADDR_INSTR = 8'h00;
   localparam logic [7:0] ADDR_WREG = 8'h04;
   localparam logic [7:0] ADDR_PC = 8'h08;
   localparam logic [7:0] ADDR_HIGH_LATCH = 8'h0c;
   localparam logic [7:0] ADDR_STACK_TOP = 8'h10;
   localparam logic [7:0] ADDR_STATUS = 8'h14;
   localparam logic [7:0] ADDR_FILE_ADDR = 8'h18;
   localparam logic [7:0] ADDR_FILE_DATA = 8'h1c;

   // ------------------------------------------------------------
   // widths, field positions and reset values
   // ------------------------------------------------------------
   localparam int PC_W = 15;
   localparam int PC_LOW_W = 8;
   localparam int LATCH_W = 7;
   localparam int FILE_AW = 7;
   localparam int FILE_DEPTH = 128;
   localparam int INSTR_W = 11;
   localparam int STATUS_W = 5;
   localparam logic [PC_W-1:0] PC_RESET = 15'h0000;
   localparam logic [PC_W-1:0] PC_STEP = 15'h0001;
   localparam logic [7:0] WREG_RESET = 8'h00;
   localparam logic [7:0] FILE_RESET = 8'h00;
   localparam logic [7:0] DEC_STEP = 8'h01;
   localparam logic [LATCH_W-1:0] LATCH_RESET = 7'h00;
   localparam logic [FILE_AW-1:0] FADDR_RESET = 7'h00;

   // ------------------------------------------------------------
   // instruction encoding
   // ------------------------------------------------------------
   typedef enum logic [2:0]
   {
      OP_CALL_W = 3'h0,
      OP_CLEAR_FILE = 3'h1,
      OP_CLEAR_W = 3'h2,
      OP_WATCHDOG_CLEAR = 3'h3,
      OP_COMPLEMENT = 3'h4,
      OP_DECREMENT = 3'h5,
      OP_DEC_SKIP_ZERO = 3'h6
   } bce_op_t;

   // word bits: [2:0] op, [3] destination, [10:4] file address
   typedef struct packed
   {
      logic [FILE_AW-1:0] fileAddr;
      logic dest;
      bce_op_t op;
   } bce_instr_t;

   localparam bce_instr_t INSTR_RESET = '{fileAddr: 7'h00, dest: 1'b0, op: OP_CALL_W};

   // word bits: [0] zero, [1] power-down n, [2] timeout n, [3] skip pending, [4] busy
   typedef struct packed
   {
      logic busy;
      logic skipPending;
      logic timeoutN;
      logic powerdownN;
      logic zero;
   } bce_status_t;

   localparam logic STATUS_ZERO_RESET = 1'b0;
   localparam logic STATUS_FLAG_N_RESET = 1'b1;

endpackage : bce_pkg

// [bce_executor.sv]
// call-via-W, clear, watchdog-clear, complement and decrement executor with APB access
`timescale 1ns/10ps

// Operation
// RULE_01: call via W pushes PC plus one
// RULE_02: then PC takes latch high, W low
// RULE_03: call via W: two cycles, flags untouched
// RULE_04: clear file writes zero, sets zero flag
// RULE_05: clear W writes zero, sets zero flag
// RULE_06: watchdog clear zeroes counter and prescaler
// RULE_07: watchdog clear sets timeout, power-down flags
// RULE_08: complement file routed by destination, zero flag
// RULE_09: decrement file routed by destination, zero flag
// RULE_10: decrement-skip zero result inserts one no-op
// RULE_11: decrement-skip nonzero result continues normally
// RULE_12: other executed instructions take one cycle
module bce_executor
(
   // clock, reset, enable
   input wire logic clk_sys,
   input wire logic arst_n,
   input wire logic ce,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // core state
   output logic [bce_pkg::PC_W-1:0] pcOut,
   output logic [bce_pkg::PC_W-1:0] stackTopOut,
   output logic busy,
   output logic instrDone,
   output logic nopInserted,
   // watchdog side
   output logic watchdogClear,
   output logic timeoutFlagN,
   output logic powerdownFlagN
);

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   function automatic logic [7:0] decOne(input logic [7:0] val);
      decOne = val - bce_pkg::DEC_STEP;
   endfunction : decOne

   function automatic logic isZero(input logic [7:0] val);
      isZero = (val == 8'h00);
   endfunction : isZero

   function automatic logic legalOp(input logic [2:0] code);
      legalOp = (code <= 3'h6);
   endfunction : legalOp

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   typedef enum logic [1:0]
   {
      ST_IDLE,
      ST_EXEC,
      ST_SECOND
   } bce_state_t;

   bce_state_t state_ff;
   bce_state_t nxt_state;
   bce_pkg::bce_instr_t instr_ff;
   logic [7:0] wReg_ff;
   logic [bce_pkg::PC_W-1:0] pc_ff;
   logic [bce_pkg::PC_W-1:0] stackTop_ff;
   logic [bce_pkg::LATCH_W-1:0] highLatch_ff;
   logic [bce_pkg::FILE_AW-1:0] fileAddr_ff;
   logic [7:0] fileMem [bce_pkg::FILE_DEPTH];
   logic zero_ff;
   logic timeoutN_ff;
   logic powerdownN_ff;
   logic skipPending_ff;
   logic [31:0] prdata_ff;
   logic instrDone_ff;
   logic nopInserted_ff;
   logic watchdogClear_ff;

   logic accessPh;
   logic setupPh;
   logic wrAcc;
   logic addrHit;
   logic wrRefused;
   logic wrOk;
   logic launch;
   logic inExec;
   logic inSecond;
   logic [7:0] fileVal;
   logic [7:0] result;
   logic resultZero;
   logic writesFile;
   logic writesW;
   bce_pkg::bce_instr_t newInstr;
   bce_pkg::bce_status_t statusWord;

   // ------------------------------------------------------------
   // bus decode
   // ------------------------------------------------------------
   assign setupPh = psel && !penable && ce;
   assign accessPh = psel && penable && ce;
   assign wrAcc = accessPh && pwrite;
   assign newInstr = bce_pkg::bce_instr_t'(pwdata[bce_pkg::INSTR_W-1:0]);

   always_comb
   begin
      addrHit = 1'b0;
      unique case (paddr)
         bce_pkg::ADDR_INSTR,
         bce_pkg::ADDR_WREG,
         bce_pkg::ADDR_PC,
         bce_pkg::ADDR_HIGH_LATCH,
         bce_pkg::ADDR_STACK_TOP,
         bce_pkg::ADDR_STATUS,
         bce_pkg::ADDR_FILE_ADDR,
         bce_pkg::ADDR_FILE_DATA: addrHit = 1'b1;
         default: addrHit = 1'b0;
      endcase
   end

   // writes are refused while an instruction runs, to the read-only stack top,
   // and for an undefined opcode; this keeps bus and execution from racing
   assign wrRefused = busy || (paddr == bce_pkg::ADDR_STACK_TOP) ||
      ((paddr == bce_pkg::ADDR_INSTR) && !legalOp(pwdata[2:0]));
   assign wrOk = wrAcc && addrHit && !wrRefused;
   assign launch = wrOk && (paddr == bce_pkg::ADDR_INSTR);

   assign pready = ce;
   assign pslverr = psel && penable && (!addrHit || (pwrite && wrRefused));
   assign prdata = prdata_ff;

   // ------------------------------------------------------------
   // sequencer
   // ------------------------------------------------------------
   assign busy = (state_ff != ST_IDLE);
   assign inExec = (state_ff == ST_EXEC);
   assign inSecond = (state_ff == ST_SECOND);

   always_comb
   begin
      nxt_state = state_ff;
      unique case (state_ff)
         ST_IDLE:
         begin
            if (launch)
            begin
               nxt_state = ST_EXEC;
            end
         end
         ST_EXEC:
         begin
            // RULE_03 second cycle for call
            if (instr_ff.op == bce_pkg::OP_CALL_W)
            begin
               nxt_state = ST_SECOND;
            end
            // RULE_10 skip costs a cycle
            else if ((instr_ff.op == bce_pkg::OP_DEC_SKIP_ZERO) && resultZero)
            begin
               nxt_state = ST_SECOND;
            end
            // RULE_11 nonzero goes on
            // RULE_12 single cycle done
            else
            begin
               nxt_state = ST_IDLE;
            end
         end
         ST_SECOND:
         begin
            nxt_state = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         state_ff <= ST_IDLE;
      end
      else if (ce)
      begin
         state_ff <= nxt_state;
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         instr_ff <= bce_pkg::INSTR_RESET;
      end
      else if (ce && launch)
      begin
         instr_ff <= newInstr;
      end
   end

   // ------------------------------------------------------------
   // datapath
   // ------------------------------------------------------------
   assign fileVal = fileMem[instr_ff.fileAddr];

   always_comb
   begin
      result = 8'h00;
      unique case (instr_ff.op)
         // RULE_08 invert every bit
         bce_pkg::OP_COMPLEMENT: result = ~fileVal;
         // RULE_09 subtract one
         bce_pkg::OP_DECREMENT: result = decOne(fileVal);
         bce_pkg::OP_DEC_SKIP_ZERO: result = decOne(fileVal);
         default: result = 8'h00;
      endcase
   end

   assign resultZero = isZero(result);

   always_comb
   begin
      writesFile = 1'b0;
      writesW = 1'b0;
      unique case (instr_ff.op)
         // RULE_04 clear selected file
         bce_pkg::OP_CLEAR_FILE: writesFile = 1'b1;
         // RULE_05 clear working register
         bce_pkg::OP_CLEAR_W: writesW = 1'b1;
         bce_pkg::OP_COMPLEMENT,
         bce_pkg::OP_DECREMENT,
         bce_pkg::OP_DEC_SKIP_ZERO:
         begin
            writesFile = instr_ff.dest;
            writesW = !instr_ff.dest;
         end
         default:
         begin
            writesFile = 1'b0;
            writesW = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         for (int i = 0; i < bce_pkg::FILE_DEPTH; i++)
         begin
            fileMem[i] <= bce_pkg::FILE_RESET;
         end
      end
      else if (ce)
      begin
         if (inExec && writesFile)
         begin
            fileMem[instr_ff.fileAddr] <= result;
         end
         else if (wrOk && (paddr == bce_pkg::ADDR_FILE_DATA))
         begin
            fileMem[fileAddr_ff] <= pwdata[7:0];
         end
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         wReg_ff <= bce_pkg::WREG_RESET;
      end
      else if (ce)
      begin
         if (inExec && writesW)
         begin
            wReg_ff <= result;
         end
         else if (wrOk && (paddr == bce_pkg::ADDR_WREG))
         begin
            wReg_ff <= pwdata[7:0];
         end
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         pc_ff <= bce_pkg::PC_RESET;
      end
      else if (ce)
      begin
         if (inExec && (instr_ff.op != bce_pkg::OP_CALL_W))
         begin
            pc_ff <= pc_ff + bce_pkg::PC_STEP;
         end
         // RULE_02 load from latch and W
         else if (inSecond && (instr_ff.op == bce_pkg::OP_CALL_W))
         begin
            pc_ff <= {highLatch_ff, wReg_ff};
         end
         // RULE_10 discarded word skipped
         else if (inSecond)
         begin
            pc_ff <= pc_ff + bce_pkg::PC_STEP;
         end
         else if (wrOk && (paddr == bce_pkg::ADDR_PC))
         begin
            pc_ff <= pwdata[bce_pkg::PC_W-1:0];
         end
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         stackTop_ff <= bce_pkg::PC_RESET;
      end
      // RULE_01 push return address
      else if (ce && inExec && (instr_ff.op == bce_pkg::OP_CALL_W))
      begin
         stackTop_ff <= pc_ff + bce_pkg::PC_STEP;
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         highLatch_ff <= bce_pkg::LATCH_RESET;
         fileAddr_ff <= bce_pkg::FADDR_RESET;
      end
      else if (ce && wrOk)
      begin
         if (paddr == bce_pkg::ADDR_HIGH_LATCH)
         begin
            highLatch_ff <= pwdata[bce_pkg::LATCH_W-1:0];
         end
         if (paddr == bce_pkg::ADDR_FILE_ADDR)
         begin
            fileAddr_ff <= pwdata[bce_pkg::FILE_AW-1:0];
         end
      end
   end

   // ------------------------------------------------------------
   // status flags
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         zero_ff <= bce_pkg::STATUS_ZERO_RESET;
         timeoutN_ff <= bce_pkg::STATUS_FLAG_N_RESET;
         powerdownN_ff <= bce_pkg::STATUS_FLAG_N_RESET;
      end
      else if (ce)
      begin
         if (inExec)
         begin
            // RULE_03 call leaves flags
            unique case (instr_ff.op)
               bce_pkg::OP_CLEAR_FILE,
               bce_pkg::OP_CLEAR_W: zero_ff <= 1'b1;
               bce_pkg::OP_COMPLEMENT,
               bce_pkg::OP_DECREMENT: zero_ff <= resultZero;
               // RULE_07 set both flags
               bce_pkg::OP_WATCHDOG_CLEAR:
               begin
                  timeoutN_ff <= 1'b1;
                  powerdownN_ff <= 1'b1;
               end
               default:
               begin
                  zero_ff <= zero_ff;
               end
            endcase
         end
         else if (wrOk && (paddr == bce_pkg::ADDR_STATUS))
         begin
            zero_ff <= pwdata[0];
            powerdownN_ff <= pwdata[1];
            timeoutN_ff <= pwdata[2];
         end
      end
   end

   // ------------------------------------------------------------
   // event pulses
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         instrDone_ff <= 1'b0;
         nopInserted_ff <= 1'b0;
         watchdogClear_ff <= 1'b0;
         skipPending_ff <= 1'b0;
      end
      else if (ce)
      begin
         instrDone_ff <= busy && (nxt_state == ST_IDLE);
         nopInserted_ff <= inSecond && (instr_ff.op == bce_pkg::OP_DEC_SKIP_ZERO);
         // RULE_06 clear counter and prescaler
         watchdogClear_ff <= inExec && (instr_ff.op == bce_pkg::OP_WATCHDOG_CLEAR);
         skipPending_ff <= inExec && (instr_ff.op == bce_pkg::OP_DEC_SKIP_ZERO) && resultZero;
      end
   end

   // ------------------------------------------------------------
   // read data, captured in the setup cycle
   // ------------------------------------------------------------
   assign statusWord = '{busy: busy, skipPending: skipPending_ff, timeoutN: timeoutN_ff,
      powerdownN: powerdownN_ff, zero: zero_ff};

   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         prdata_ff <= 32'h0000_0000;
      end
      else if (setupPh)
      begin
         prdata_ff <= 32'h0000_0000;
         unique case (paddr)
            bce_pkg::ADDR_INSTR: prdata_ff[bce_pkg::INSTR_W-1:0] <= instr_ff;
            bce_pkg::ADDR_WREG: prdata_ff[7:0] <= wReg_ff;
            bce_pkg::ADDR_PC: prdata_ff[bce_pkg::PC_W-1:0] <= pc_ff;
            bce_pkg::ADDR_HIGH_LATCH: prdata_ff[bce_pkg::LATCH_W-1:0] <= highLatch_ff;
            bce_pkg::ADDR_STACK_TOP: prdata_ff[bce_pkg::PC_W-1:0] <= stackTop_ff;
            bce_pkg::ADDR_STATUS: prdata_ff[bce_pkg::STATUS_W-1:0] <= statusWord;
            bce_pkg::ADDR_FILE_ADDR: prdata_ff[bce_pkg::FILE_AW-1:0] <= fileAddr_ff;
            bce_pkg::ADDR_FILE_DATA: prdata_ff[7:0] <= fileMem[fileAddr_ff];
            default: prdata_ff <= 32'h0000_0000;
         endcase
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign pcOut = pc_ff;
   assign stackTopOut = stackTop_ff;
   assign instrDone = instrDone_ff;
   assign nopInserted = nopInserted_ff;
   assign watchdogClear = watchdogClear_ff;
   assign timeoutFlagN = timeoutN_ff;
   assign powerdownFlagN = powerdownN_ff;

endmodule : bce_executor

// [bce_executor_properties.sv]
// port-level assertion checker for the call/clear/decrement executor
`timescale 1ns/10ps
module bce_executor_properties
(
   // clock, reset, enable
   input wire logic clk_sys,
   input wire logic arst_n,
   input wire logic ce,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // core state
   input wire logic [bce_pkg::PC_W-1:0] pcOut,
   input wire logic [bce_pkg::PC_W-1:0] stackTopOut,
   input wire logic busy,
   input wire logic instrDone,
   input wire logic nopInserted,
   // watchdog side
   input wire logic watchdogClear,
   input wire logic timeoutFlagN,
   input wire logic powerdownFlagN
);
   logic launch;
   logic wdLaunch;
   logic [2:0] op;

   // accepted instruction write
   assign launch = psel && penable && pwrite && ce && !pslverr && paddr == bce_pkg::ADDR_INSTR;
   assign op = pwdata[2:0];
   assign wdLaunch = launch && op == 3'h3;

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!arst_n);

   a_call_push: assert property (
      launch && op == 3'h0 |-> ##2 stackTopOut == $past(pcOut, 2) + bce_pkg::PC_STEP)
      else $error("return address not pushed");
   a_call_cycles: assert property (
      launch && op == 3'h0 |-> ##1 busy ##1 (busy && !instrDone) ##1 (instrDone && !busy))
      else $error("call does not take two cycles");
   a_call_flags: assert property (
      launch && op == 3'h0 |-> ##1 ($stable(timeoutFlagN) && $stable(powerdownFlagN))[*3])
      else $error("call changed status flags");
   a_wdt_pulse: assert property (
      wdLaunch |-> ##1 !watchdogClear ##1 watchdogClear ##1 !watchdogClear)
      else $error("watchdog clear pulse wrong");
   a_wdt_flags: assert property (
      wdLaunch |-> ##2 timeoutFlagN && powerdownFlagN)
      else $error("watchdog clear left flags low");
   a_wdt_cause: assert property (
      watchdogClear |-> $past(wdLaunch, 2))
      else $error("watchdog clear pulse without cause");
   a_one_cycle: assert property (
      launch && op inside {3'h1, 3'h2, 3'h4, 3'h5}
      |-> ##1 busy ##1 (!busy && instrDone && pcOut == $past(pcOut, 2) + bce_pkg::PC_STEP))
      else $error("single-cycle op timing wrong");
   a_skip_branch: assert property (
      launch && op == 3'h6
      |-> ##2 ((instrDone && !nopInserted) or (!instrDone ##1 (instrDone && nopInserted))))
      else $error("decrement-skip length wrong");
   a_skip_nop: assert property (
      nopInserted |-> instrDone && pcOut == $past(pcOut, 2) + 15'h0002)
      else $error("inserted no-op did not advance pc");
endmodule : bce_executor_properties

bind bce_executor bce_executor_properties u_props
(
   .clk_sys(clk_sys), .arst_n(arst_n), .ce(ce), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .pcOut(pcOut), .stackTopOut(stackTopOut), .busy(busy),
   .instrDone(instrDone), .nopInserted(nopInserted), .watchdogClear(watchdogClear),
   .timeoutFlagN(timeoutFlagN), .powerdownFlagN(powerdownFlagN)
);

// [bce_executor_tb.sv]
// self-checking bench for the call/clear/decrement executor
`timescale 1ns/10ps
module bce_executor_tb;
   typedef struct packed
   {
      logic [10:0] instr;
      logic [7:0] fval;
      logic [7:0] expW;
      logic [7:0] expF;
      logic [2:0] expStat;
   } bce_row_t;

   logic clk_sys, arst_n, ce, psel, penable, pwrite, pready, pslverr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd, pc0;
   logic [14:0] pcOut, stackTopOut, pcExp;
   logic busy, instrDone, nopInserted, watchdogClear, timeoutFlagN, powerdownFlagN;
   logic er, nop, wd, skip, call;
   logic [7:0] res;
   bce_row_t r;
   int fails, comparisons, cycles, n;
   // instr, file value, W after, file after, {timeout_n, powerdown_n, zero}
   bce_row_t rows [10] = '{'{11'h000, 8'h11, 8'hc3, 8'h11, 3'h0},
      '{11'h7f1, 8'ha5, 8'hc3, 8'h00, 3'h1}, '{11'h052, 8'h33, 8'h00, 8'h33, 3'h1},
      '{11'h003, 8'h44, 8'hc3, 8'h44, 3'h6}, '{11'h014, 8'hff, 8'h00, 8'hff, 3'h1},
      '{11'h02c, 8'h0f, 8'hc3, 8'hf0, 3'h0}, '{11'h035, 8'h01, 8'h00, 8'h01, 3'h1},
      '{11'h00d, 8'h00, 8'hc3, 8'hff, 3'h0}, '{11'h04e, 8'h01, 8'hc3, 8'h00, 3'h0},
      '{11'h066, 8'h02, 8'h01, 8'h02, 3'h0}};

   bce_executor dut
   (
      .clk_sys(clk_sys), .arst_n(arst_n), .ce(ce), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .pcOut(pcOut), .stackTopOut(stackTopOut), .busy(busy),
      .instrDone(instrDone), .nopInserted(nopInserted), .watchdogClear(watchdogClear),
      .timeoutFlagN(timeoutFlagN), .powerdownFlagN(powerdownFlagN)
   );

   initial
   begin
      clk_sys = 1'h0;
      forever #2.5 clk_sys = ~clk_sys;
   end

   task report_and_stop;
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : report_and_stop

   task check(input logic [31:0] got, input logic [31:0] exp, input string what);
      comparisons++;
      if (got !== exp)
      begin
         fails++;
         $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
      end
   endtask : check

   // access phase: penable up, answer taken at the edge where pready is high
   task apb_access(output logic [31:0] q, output logic e);
      @(posedge clk_sys);
      penable <= 1'h1;
      do
      begin
         @(posedge clk_sys);
      end
      while (pready !== 1'h1);
      q = prdata;
      e = pslverr;
   endtask : apb_access

   // one apb transfer, zero or more wait states
   task apb(input logic [7:0] a, input logic w, input logic [31:0] d,
            output logic [31:0] q, output logic e);
      @(posedge clk_sys);
      psel <= 1'h1;
      penable <= 1'h0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      apb_access(q, e);
      psel <= 1'h0;
      penable <= 1'h0;
   endtask : apb

   // two writes back to back: second setup follows the first access at once
   task apb_pair(input logic [7:0] a1, input logic [31:0] d1, input logic [7:0] a2,
                 input logic [31:0] d2, output logic e);
      @(posedge clk_sys);
      psel <= 1'h1;
      penable <= 1'h0;
      pwrite <= 1'h1;
      paddr <= a1;
      pwdata <= d1;
      apb_access(rd, e);
      penable <= 1'h0;
      paddr <= a2;
      pwdata <= d2;
      apb_access(rd, e);
      psel <= 1'h0;
      penable <= 1'h0;
   endtask : apb_pair

   always @(posedge clk_sys)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         fails++;
         report_and_stop;
      end
   end

   initial
   begin
      {arst_n, psel, penable, pwrite, paddr, pwdata} = '0;
      ce = 1'h1;
      repeat (8) @(posedge clk_sys);
      arst_n <= 1'h1;
      for (int i = 0; i < 10; i++)
      begin
         r = rows[i];
         apb(bce_pkg::ADDR_FILE_ADDR, 1'h1, {25'h0, r.instr[10:4]}, rd, er);
         apb(bce_pkg::ADDR_FILE_DATA, 1'h1, {24'h0, r.fval}, rd, er);
         apb(bce_pkg::ADDR_WREG, 1'h1, 32'hc3, rd, er);
         apb(bce_pkg::ADDR_HIGH_LATCH, 1'h1, 32'h2b, rd, er);
         apb(bce_pkg::ADDR_STATUS, 1'h1, 32'h0, rd, er);
         apb(bce_pkg::ADDR_PC, 1'h0, 32'h0, pc0, er);
         res = r.fval - 8'h01;
         call = r.instr[2:0] == 3'h0;
         skip = r.instr[2:0] == 3'h6 && res == 8'h00;
         apb(bce_pkg::ADDR_INSTR, 1'h1, {21'h0, r.instr}, rd, er);
         n = 0;
         nop = 1'h0;
         wd = 1'h0;
         do
         begin
            @(posedge clk_sys);
            n++;
            nop = nop | nopInserted;
            wd = wd | watchdogClear;
         end
         while (instrDone !== 1'h1 && n < 10);
         check(n, (call || skip) ? 3 : 2, "cycles");
         check(nop, skip, "no-op");
         check(wd, r.instr[2:0] == 3'h3, "watchdog pulse");
         apb(bce_pkg::ADDR_WREG, 1'h0, 32'h0, rd, er);
         check(rd, r.expW, "W");
         apb(bce_pkg::ADDR_FILE_DATA, 1'h0, 32'h0, rd, er);
         check(rd, r.expF, "file");
         apb(bce_pkg::ADDR_STATUS, 1'h0, 32'h0, rd, er);
         check(rd[2:0], r.expStat, "status");
         pcExp = call ? {7'h2b, 8'hc3} : pc0[14:0] + 15'h0001 + {14'h0, skip};
         apb(bce_pkg::ADDR_PC, 1'h0, 32'h0, rd, er);
         check(rd, pcExp, "pc");
         if (call)
            check(stackTopOut, pc0[14:0] + 15'h0001, "stack top");
         $display("row %0d done", i);
      end
      // refused accesses and a write while busy
      apb(8'h20, 1'h0, 32'h0, rd, er);
      check(er, 1'h1, "unmapped error");
      check(rd, 32'h0, "unmapped data");
      apb(bce_pkg::ADDR_STACK_TOP, 1'h1, 32'h5, rd, er);
      check(er, 1'h1, "stack top write");
      apb(bce_pkg::ADDR_INSTR, 1'h1, 32'h7, rd, er);
      check({er, busy}, 2'h2, "bad op");
      apb(bce_pkg::ADDR_WREG, 1'h1, 32'hc3, rd, er);
      apb_pair(bce_pkg::ADDR_INSTR, 32'h0, bce_pkg::ADDR_WREG, 32'h11, er);
      check(er, 1'h1, "write while busy");
      apb(bce_pkg::ADDR_WREG, 1'h0, 32'h0, rd, er);
      check(rd, 32'hc3, "W kept");
      $display("refusal test done");
      // clock enable low stalls the bus until it returns
      ce <= 1'h0;
      fork
         apb(bce_pkg::ADDR_WREG, 1'h1, 32'h5a, rd, er);
         begin
            repeat (4) @(posedge clk_sys);
            check(pready, 1'h0, "ready while stalled");
            ce <= 1'h1;
         end
      join
      apb(bce_pkg::ADDR_WREG, 1'h0, 32'h0, rd, er);
      check(rd, 32'h5a, "W after stall");
      $display("enable test done");
      // reset in mid-run with flags cleared beforehand
      apb(bce_pkg::ADDR_STATUS, 1'h1, 32'h0, rd, er);
      arst_n <= 1'h0;
      repeat (2) @(posedge clk_sys);
      check({pcOut, stackTopOut}, 30'h0, "pc after reset");
      check({timeoutFlagN, powerdownFlagN, busy, instrDone}, 4'hc, "flags after reset");
      arst_n <= 1'h1;
      apb(bce_pkg::ADDR_STATUS, 1'h0, 32'h0, rd, er);
      check(rd[2:0], 3'h6, "status after reset");
      $display("reset test done");
      report_and_stop;
   end
endmodule : bce_executor_tb
